// file: oshp_defines.svh
// Purpose: Shared constants for the octal serdes host port and its MAC end
// Assumes: Channels A..H are indices 0..7; pair p holds channels 2p and 2p+1
// Notes:   Included by the package; definitions only
`ifndef OSHP_DEFINES_SVH
`define OSHP_DEFINES_SVH

// ---------------------------------------------------------------
// Geometry
// ---------------------------------------------------------------
`define OSHP_CH       8
`define OSHP_PAIRS    4
`define OSHP_WORD_W   10
`define OSHP_KBIT     8
`define OSHP_PTR_W    3
`define OSHP_RING_N   4

// ---------------------------------------------------------------
// Bus phase counter: one bus clock period is four core cycles
// ---------------------------------------------------------------
`define OSHP_PH_RISE  2'h0
`define OSHP_PH_FALL  2'h2
`define OSHP_PH_LAST  2'h3

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define OSHP_RD_RESET 1'b0

// ---------------------------------------------------------------
// Device configuration vector bit positions
// ---------------------------------------------------------------
`define OSHP_CFG_W       10
`define OSHP_CFG_CODE    0
`define OSHP_CFG_CODEBIT 1
`define OSHP_CFG_SELHI   2
`define OSHP_CFG_SEL2    3
`define OSHP_CFG_OVR     4
`define OSHP_CFG_OVRHI   5
`define OSHP_CFG_OVR2    6
`define OSHP_CFG_TCKPIN  7
`define OSHP_CFG_TCKBIT  8
`define OSHP_CFG_VFM     9

// ---------------------------------------------------------------
// Line code constants
// ---------------------------------------------------------------
`define OSHP_X_K28    5'h1c
`define OSHP_6B_K28   6'h0f
`define OSHP_6B_D7    6'h38
`define OSHP_4B_A7    4'h7
`define OSHP_4B_P7    4'he

`endif

// file: oshp_device.sv
// Purpose: Serdes side of the host port: mode control, DDR capture, coding
// Assumes: MCLK is the reference clock; line symbols are on MCLK
// Notes:   Mode inputs are static; change them only while RST is high
`timescale 1ns/1ps
module oshp_device
  import oshp_pkg::*;
(
  input  wire logic                 MCLK,
  input  wire logic                 RST,
  input  wire logic                 CODE_PIN,
  input  wire logic                 CODING_ENABLE_BIT,
  input  wire logic                 IFACE_SELECT_HIGH,
  input  wire logic                 IFACE_SELECT_SECOND,
  input  wire logic                 IFACE_SELECT_OVERRIDE,
  input  wire logic                 OVR_SELECT_HIGH,
  input  wire logic                 OVR_SELECT_SECOND,
  input  wire logic                 TX_CLOCK_SELECT_PIN,
  input  wire logic                 TX_CLOCKING_BIT,
  input  wire logic                 VIOLATION_FLAG_MODE,
  input  wire logic [7:0][9:0]      LINE_RX,
  input  wire logic [7:0]           LINE_RX_VALID,
  output logic      [7:0][9:0]      LINE_TX,
  output logic      [7:0]           LINE_TX_VALID,
  output logic                      CODED_MODE,
  output logic                      NIBBLE_MODE,
  output logic                      INDEPENDENT_CLOCKING,
  output logic                      CONFIG_INVALID,
  oshp_link_if.dev                  link
);

  typedef struct packed {
    logic [`OSHP_CFG_W-1:0]  cfg_s1;
    logic [`OSHP_CFG_W-1:0]  cfg;
    logic [3:0][2:0]         wp_s1;
    logic [3:0][2:0]         wp_s2;
    logic [3:0][2:0]         rptr;
    logic [7:0]              tx_rd;
    logic [7:0]              rx_rd;
    logic [7:0][9:0]         line_tx;
    logic [7:0]              line_tx_valid;
    logic [7:0][9:0]         rx_word;
    logic [1:0]              phase;
    logic                    rx_clk;
    logic [3:0][9:0]         rx_bus;
  } oshp_dev_state_t;

  oshp_dev_state_t         q;
  oshp_dev_state_t         n;
  oshp_layout_t            layout;
  logic                    coded;
  logic                    indep;
  logic                    sel_hi;
  logic                    sel_2;
  logic [3:0][2:0]         wgray_all;
  logic [3:0][3:0][19:0]   ring_all;
  logic [19:0]             entry;
  logic [1:0][9:0]         pr;
  oshp_enc_t               enc;
  oshp_dec_t               dec;
  logic [1:0]              next_phase;

  // ---------------------------------------------------------------
  // Mode decode from the synchronised configuration
  // ---------------------------------------------------------------
  always_comb begin
    coded  = q.cfg[`OSHP_CFG_CODE] | q.cfg[`OSHP_CFG_CODEBIT];
    sel_hi = q.cfg[`OSHP_CFG_OVR] ? q.cfg[`OSHP_CFG_OVRHI] : q.cfg[`OSHP_CFG_SELHI];
    sel_2  = q.cfg[`OSHP_CFG_OVR] ? q.cfg[`OSHP_CFG_OVR2] : q.cfg[`OSHP_CFG_SEL2];
    indep  = q.cfg[`OSHP_CFG_TCKPIN] | q.cfg[`OSHP_CFG_TCKBIT];
    case ({sel_hi, sel_2})
      2'h0: layout = OSHP_MUXED;
      2'h2: layout = OSHP_NIBBLE;
      default: layout = OSHP_RESERVED;
    endcase
  end

  // ---------------------------------------------------------------
  // Transmit capture on the link clocks
  // ---------------------------------------------------------------
  // The clock mux follows a static mode bit, so it never switches mid-frame
  for (genvar p = 0; p < `OSHP_PAIRS; p++) begin : g_pair
    logic             wclk;
    logic [1:0]       lrst;
    logic [9:0]       rise_w;
    logic [3:0][19:0] ring;
    logic [2:0]       wbin;
    logic [2:0]       wgray;

    assign wclk = indep ? link.tx_clk[p] : link.tx_clk[0];

    // Rising beat held until the falling beat completes the pair
    always_ff @(posedge wclk) begin
      rise_w <= link.tx_bus[p];
    end

    // Falling edge stores both beats; pointer is gray so MCLK can sample it
    always_ff @(negedge wclk) begin
      lrst <= {lrst[0], RST};
      if (lrst[1]) begin
        wbin  <= 3'h0;
        wgray <= 3'h0;
      end else begin
        ring[wbin[1:0]] <= {rise_w, link.tx_bus[p]};
        wbin            <= wbin + 3'h1;
        wgray           <= oshp_gray(wbin + 3'h1);
      end
    end

    assign wgray_all[p] = wgray;
    assign ring_all[p]  = ring;
  end

  // ---------------------------------------------------------------
  // Core next-state logic
  // ---------------------------------------------------------------
  // The reader drains one entry per MCLK, faster than any bus clock can
  // write, so the ring needs no full flag (host clocks are MCLK/4)
  always_comb begin
    n          = q;
    entry      = '0;
    pr         = '0;
    enc        = '0;
    dec        = '0;
    next_phase = q.phase + 2'h1;
    n.cfg_s1 = {VIOLATION_FLAG_MODE, TX_CLOCKING_BIT, TX_CLOCK_SELECT_PIN, OVR_SELECT_SECOND,
                OVR_SELECT_HIGH, IFACE_SELECT_OVERRIDE, IFACE_SELECT_SECOND, IFACE_SELECT_HIGH,
                CODING_ENABLE_BIT, CODE_PIN};
    n.cfg    = q.cfg_s1;
    n.wp_s1  = wgray_all;
    n.wp_s2  = q.wp_s1;
    n.line_tx_valid = '0;

    // Transmit: retime into MCLK, split per layout, then code
    for (int p = 0; p < `OSHP_PAIRS; p++) begin
      if (q.wp_s2[p] != oshp_gray(q.rptr[p])) begin
        n.rptr[p] = q.rptr[p] + 3'h1;
        entry     = ring_all[p][q.rptr[p][1:0]];
        pr        = oshp_unpack(entry[19:10], entry[9:0], layout == OSHP_NIBBLE);
        if (layout != OSHP_RESERVED) begin
          for (int j = 0; j < 2; j++) begin
            if (coded) begin
              enc = oshp_encode(pr[j][7:0], pr[j][`OSHP_KBIT], q.tx_rd[2*p+j]);
              n.line_tx[2*p+j] = enc.sym;
              n.tx_rd[2*p+j]   = enc.rd;
            end else begin
              n.line_tx[2*p+j] = pr[j];
            end
            n.line_tx_valid[2*p+j] = 1'b1;
          end
        end
      end
    end

    // Receive: decode each symbol and keep the latest word per channel
    for (int c = 0; c < `OSHP_CH; c++) begin
      if (LINE_RX_VALID[c]) begin
        if (coded) begin
          dec        = oshp_decode(LINE_RX[c], q.rx_rd[c]);
          n.rx_rd[c] = dec.rd;
          n.rx_word[c] = {1'b0, dec.k, dec.data};
          if (q.cfg[`OSHP_CFG_VFM] && (dec.cv || dec.rderr))
            n.rx_word[c] = 10'h1ff;
          else if (!q.cfg[`OSHP_CFG_VFM] && dec.cv)
            n.rx_word[c] = 10'h0ff;
        end else begin
          n.rx_word[c] = LINE_RX[c];
        end
      end
    end

    // Receive bus: data launched one cycle before each clock edge
    n.phase  = next_phase;
    n.rx_clk = next_phase[0] ^ next_phase[1];
    for (int p = 0; p < `OSHP_PAIRS; p++) begin
      pr = oshp_pack(q.rx_word[2*p], q.rx_word[2*p+1], layout == OSHP_NIBBLE);
      if (layout == OSHP_RESERVED)
        n.rx_bus[p] = '0;
      else if (next_phase == `OSHP_PH_RISE)
        n.rx_bus[p] = pr[1];
      else if (next_phase == `OSHP_PH_FALL)
        n.rx_bus[p] = pr[0];
    end
  end

  // All of q clears to zero, which is also negative running disparity; the pair rings and beat holds are not cleared
  always_ff @(posedge MCLK) begin
    if (RST)
      q <= '0;
    else
      q <= n;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign LINE_TX              = q.line_tx;
  assign LINE_TX_VALID        = q.line_tx_valid;
  assign CODED_MODE           = coded;
  assign NIBBLE_MODE          = layout == OSHP_NIBBLE;
  assign INDEPENDENT_CLOCKING = indep;
  assign CONFIG_INVALID       = layout == OSHP_RESERVED;
  assign link.rx_clk          = q.rx_clk;
  assign link.rx_bus          = q.rx_bus;

endmodule : oshp_device

// file: oshp_link_asserts.sv
// Purpose: Concurrent checks on the DDR link between the device and MAC ends
// Assumes: Both link clocks are MCLK/4; RST is the later-released device reset
// Notes:   Watches the interface wires only; user ports are judged by the bench
`timescale 1ns/1ps
module oshp_link_asserts (
  input wire logic            MCLK,
  input wire logic            RST,
  input wire logic [3:0]      tx_clk,
  input wire logic [3:0][9:0] tx_bus,
  input wire logic            rx_clk,
  input wire logic [3:0][9:0] rx_bus
);
  // ---------------------------------------------------------------
  // Link clocking and data centring
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  // Clock periods: exactly four reference cycles, half high
  a_tx_clk_period: assert property ($rose(tx_clk[0]) |-> tx_clk[0] ##1 tx_clk[0] ##1 !tx_clk[0]
    ##1 !tx_clk[0] ##1 tx_clk[0])
    else $error("transmit clock period is not four cycles");
  a_rx_clk_period: assert property ($rose(rx_clk) |-> rx_clk ##1 rx_clk ##1 !rx_clk ##1 !rx_clk ##1 rx_clk)
    else $error("receive clock period is not four cycles");
  a_pair_clk_equal: assert property (tx_clk == {4{tx_clk[0]}})
    else $error("pair transmit clocks differ");
  // Bus never moves on a clock edge, so both edges see a settled beat
  a_tx_rise_stable: assert property ($rose(tx_clk[0]) |-> $stable(tx_bus))
    else $error("transmit bus moved at rising edge");
  a_tx_fall_stable: assert property ($fell(tx_clk[0]) |-> $stable(tx_bus))
    else $error("transmit bus moved at falling edge");
  a_rx_rise_stable: assert property ($rose(rx_clk) |-> $stable(rx_bus))
    else $error("receive bus moved at rising edge");
  a_rx_fall_stable: assert property ($fell(rx_clk) |-> $stable(rx_bus))
    else $error("receive bus moved at falling edge");
  // A new beat is launched one cycle ahead of the edge it belongs to
  a_tx_launch_lead: assert property ($changed(tx_bus) |=> $changed(tx_clk[0]))
    else $error("transmit beat not one cycle before an edge");
  a_rx_launch_lead: assert property ($changed(rx_bus) |=> $changed(rx_clk))
    else $error("receive beat not one cycle before an edge");

  c_tx_clk_runs: cover property ($rose(tx_clk[0]));
  c_rx_clk_runs: cover property ($rose(rx_clk));
  c_rx_data_moves: cover property ($changed(rx_bus));
endmodule : oshp_link_asserts

// file: oshp_link_if.sv
// Purpose: Parallel DDR bus between the serdes host port and the MAC
// Assumes: One 10-bit bus and one transmit clock per channel pair
// Notes:   All wires are one-way; no resolution needed
`timescale 1ns/1ps
interface oshp_link_if;
  logic [3:0]      tx_clk;
  logic [3:0][9:0] tx_bus;
  logic            rx_clk;
  logic [3:0][9:0] rx_bus;

  modport dev (input tx_clk, input tx_bus, output rx_clk, output rx_bus);
  modport mac (output tx_clk, output tx_bus, input rx_clk, input rx_bus);
endinterface : oshp_link_if

// file: oshp_mac.sv
// Purpose: MAC side of the host port: drives DDR transmit, takes receive
// Assumes: MCLK runs at the device reference frequency
// Notes:   Transmit clocks are MCLK divided by four, one per channel pair
`timescale 1ns/1ps
module oshp_mac
  import oshp_pkg::*;
(
  input  wire logic                 MCLK,
  input  wire logic                 RST,
  input  wire logic                 NIBBLE_LAYOUT,
  input  wire logic                 RATE_COMP_OFF_REQUEST,
  input  wire logic [7:0][9:0]      TX_DATA,
  input  wire logic                 TX_VALID,
  output logic                      TX_READY,
  output logic      [7:0][9:0]      RX_DATA,
  output logic                      RX_VALID,
  output logic                      RATE_COMP_ENABLE,
  oshp_link_if.mac                  link
);

  typedef struct packed {
    logic [1:0]       cfg_s1;
    logic [1:0]       cfg;
    logic [1:0]       phase;
    logic             tx_clk;
    logic [7:0][9:0]  tx_word;
    logic [3:0][9:0]  tx_bus;
    logic             rclk_s1;
    logic             rclk_s2;
    logic             rclk_s3;
    logic [3:0][9:0]  rbus_s1;
    logic [3:0][9:0]  rbus_s2;
    logic [3:0][9:0]  rise_hold;
    logic [7:0][9:0]  rx_data;
    logic             rx_valid;
  } oshp_mac_state_t;

  oshp_mac_state_t q;
  oshp_mac_state_t n;
  logic [1:0]      next_phase;
  logic [1:0][9:0] pr;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    n          = q;
    pr         = '0;
    next_phase = q.phase + 2'h1;
    n.cfg_s1   = {RATE_COMP_OFF_REQUEST, NIBBLE_LAYOUT};
    n.cfg      = q.cfg_s1;

    // One set of eight words per bus clock period; idle repeats the last set
    if (TX_VALID && q.phase == `OSHP_PH_LAST)
      n.tx_word = TX_DATA;
    n.phase  = next_phase;
    n.tx_clk = next_phase[0] ^ next_phase[1];
    for (int p = 0; p < `OSHP_PAIRS; p++) begin
      pr = oshp_pack(n.tx_word[2*p], n.tx_word[2*p+1], q.cfg[0]);
      if (next_phase == `OSHP_PH_RISE)
        n.tx_bus[p] = pr[1];
      else if (next_phase == `OSHP_PH_FALL)
        n.tx_bus[p] = pr[0];
    end

    // Receive oversampled on MCLK; the beat is taken as its clock edge is seen
    n.rclk_s1  = link.rx_clk;
    n.rclk_s2  = q.rclk_s1;
    n.rclk_s3  = q.rclk_s2;
    n.rbus_s1  = link.rx_bus;
    n.rbus_s2  = q.rbus_s1;
    n.rx_valid = 1'b0;
    if (q.rclk_s2 && !q.rclk_s3)
      n.rise_hold = q.rbus_s2;
    if (!q.rclk_s2 && q.rclk_s3) begin
      for (int p = 0; p < `OSHP_PAIRS; p++) begin
        pr = oshp_unpack(q.rise_hold[p], q.rbus_s2[p], q.cfg[0]);
        n.rx_data[2*p]   = pr[0];
        n.rx_data[2*p+1] = pr[1];
      end
      n.rx_valid = 1'b1;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST)
      q <= '0;
    else
      q <= n;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // All four pair clocks come from one divider, so either clocking mode works
  assign link.tx_clk      = {4{q.tx_clk}};
  assign link.tx_bus      = q.tx_bus;
  assign TX_READY         = q.phase == `OSHP_PH_LAST;
  assign RX_DATA          = q.rx_data;
  assign RX_VALID         = q.rx_valid;
  // Disabling is refused while the layout is multiplexed
  assign RATE_COMP_ENABLE = !(q.cfg[1] && q.cfg[0]);

endmodule : oshp_mac

// file: oshp_pkg.sv
// Purpose: Types and line-code helpers shared by both ends
// Assumes: Code words carry bit a in bit 0, the first bit on the wire
// Notes:   Decode searches the encoder, trading area for one source of truth
`include "oshp_defines.svh"
package oshp_pkg;

  typedef logic [`OSHP_WORD_W-1:0] oshp_word_t;
  typedef enum logic [1:0] {OSHP_MUXED, OSHP_NIBBLE, OSHP_RESERVED} oshp_layout_t;
  typedef struct packed {oshp_word_t sym; logic rd;} oshp_enc_t;
  typedef struct packed {logic [7:0] data; logic k; logic cv; logic rderr; logic rd;} oshp_dec_t;

  // Six-bit sub-block codes, negative disparity column, index = low five bits
  localparam logic [5:0] OSHP_B6 [32] = '{
    6'h27, 6'h1d, 6'h2d, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0d, 6'h2c, 6'h1c, 6'h17,
    6'h1b, 6'h23, 6'h13, 6'h32, 6'h0b, 6'h2a, 6'h1a, 6'h3a,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0e, 6'h2e, 6'h1e, 6'h2b};
  // Four-bit sub-block codes, negative disparity column
  localparam logic [3:0] OSHP_B4 [8] = '{
    4'hb, 4'h9, 4'h5, 4'hc, 4'hd, 4'ha, 4'h6, `OSHP_4B_P7};

  function automatic logic [2:0] oshp_gray(input logic [2:0] b);
    return b ^ (b >> 1);
  endfunction : oshp_gray

  // Only the twelve defined control characters decode as K
  function automatic logic oshp_kvalid(input logic [7:0] d);
    return (d[4:0] == `OSHP_X_K28) || (d[7:5] == 3'h7 &&
           (d[4:0] == 5'h17 || d[4:0] == 5'h1b || d[4:0] == 5'h1d || d[4:0] == 5'h1e));
  endfunction : oshp_kvalid

  // Running disparity rd: 1 is positive
  function automatic oshp_enc_t oshp_encode(input logic [7:0] d, input logic k, input logic rd);
    logic [5:0] b6;
    logic [3:0] b4;
    logic       r;
    logic       k28;
    logic       alt;
    logic       comp;
    oshp_enc_t  o;
    k28 = k && (d[4:0] == `OSHP_X_K28);
    r   = rd;
    b6  = k28 ? `OSHP_6B_K28 : OSHP_B6[d[4:0]];
    if (r && ($countones(b6) != 3 || b6 == `OSHP_6B_D7))
      b6 = ~b6;
    if ($countones(b6) != 3)
      r = ~r;
    alt = k || (!r && (d[4:0] == 5'h11 || d[4:0] == 5'h12 || d[4:0] == 5'h14)) ||
          (r && (d[4:0] == 5'h0b || d[4:0] == 5'h0d || d[4:0] == 5'h0e));
    b4 = (d[7:5] == 3'h7 && alt) ? `OSHP_4B_A7 : OSHP_B4[d[7:5]];
    if (d[7:5] == 3'h7)
      comp = r;
    else if ($countones(b4) != 2 || d[7:5] == 3'h3)
      comp = r;
    else
      comp = k28 && !r;
    if (comp)
      b4 = ~b4;
    if ($countones(b4) != 2)
      r = ~r;
    o.sym = {<<{b6, b4}};
    o.rd  = r;
    return o;
  endfunction : oshp_encode

  // Exact match wins; a match only at the other disparity is a disparity error
  function automatic oshp_dec_t oshp_decode(input oshp_word_t s, input logic rd);
    oshp_dec_t o;
    oshp_dec_t a;
    logic      hit;
    logic      ahit;
    oshp_enc_t e;
    o    = '{data: 8'h00, k: 1'b0, cv: 1'b1, rderr: 1'b0, rd: rd};
    a    = o;
    hit  = 1'b0;
    ahit = 1'b0;
    for (int i = 0; i < 512; i++) begin
      if (!(i >= 256 && !oshp_kvalid(8'(i)))) begin
        e = oshp_encode(8'(i), i >= 256, rd);
        if (!hit && e.sym == s) begin
          hit = 1'b1;
          o   = '{data: 8'(i), k: i >= 256, cv: 1'b0, rderr: 1'b0, rd: e.rd};
        end
        e = oshp_encode(8'(i), i >= 256, !rd);
        if (!ahit && e.sym == s) begin
          ahit = 1'b1;
          a    = '{data: 8'(i), k: i >= 256, cv: 1'b0, rderr: 1'b1, rd: e.rd};
        end
      end
    end
    return hit ? o : a;
  endfunction : oshp_decode

  // Split a bus beat pair into {odd channel, even channel}
  function automatic logic [1:0][9:0] oshp_unpack(input oshp_word_t rise, input oshp_word_t fall,
                                                  input logic nib);
    if (nib)
      return {{fall[9:5], rise[9:5]}, {fall[4:0], rise[4:0]}};
    return {rise, fall};
  endfunction : oshp_unpack

  // Build {rising beat, falling beat} from an even and an odd channel word
  function automatic logic [1:0][9:0] oshp_pack(input oshp_word_t even, input oshp_word_t odd,
                                                input logic nib);
    if (nib)
      return {{odd[4:0], even[4:0]}, {odd[9:5], even[9:5]}};
    return {odd, even};
  endfunction : oshp_pack

endpackage : oshp_pkg

// file: tb_octal_serdes_host_port_mode_control.sv
// Purpose: Self-checking bench joining the device and MAC ends of the host port
// Assumes: Modes change only while both resets are high
// Notes:   MAC reset is released first so pair clocks run before the device leaves reset
`timescale 1ns/1ps
module tb_octal_serdes_host_port_mode_control import oshp_pkg::*;;
  logic            MCLK, RST, MAC_RST, CODE_PIN, CODING_ENABLE_BIT, IFACE_SELECT_HIGH, IFACE_SELECT_SECOND;
  logic            IFACE_SELECT_OVERRIDE, OVR_SELECT_HIGH, OVR_SELECT_SECOND, TX_CLOCK_SELECT_PIN;
  logic            TX_CLOCKING_BIT, VIOLATION_FLAG_MODE, NIBBLE_LAYOUT, RATE_COMP_OFF_REQUEST, TX_VALID;
  logic            TX_READY, RX_VALID, RATE_COMP_ENABLE, CODED_MODE, NIBBLE_MODE, INDEPENDENT_CLOCKING, CONFIG_INVALID;
  logic [7:0][9:0] LINE_RX, LINE_TX, TX_DATA, RX_DATA;
  logic [7:0]      LINE_RX_VALID, LINE_TX_VALID;
  int              num_errors = 0;
  int              n_checks = 0;

  oshp_link_if link_if ();
  oshp_device oshp_device_inst (.MCLK, .RST, .CODE_PIN, .CODING_ENABLE_BIT, .IFACE_SELECT_HIGH, .IFACE_SELECT_SECOND,
    .IFACE_SELECT_OVERRIDE, .OVR_SELECT_HIGH, .OVR_SELECT_SECOND, .TX_CLOCK_SELECT_PIN, .TX_CLOCKING_BIT,
    .VIOLATION_FLAG_MODE, .LINE_RX, .LINE_RX_VALID, .LINE_TX, .LINE_TX_VALID, .CODED_MODE, .NIBBLE_MODE,
    .INDEPENDENT_CLOCKING, .CONFIG_INVALID, .link(link_if));
  oshp_mac oshp_mac_inst (.MCLK, .RST(MAC_RST), .NIBBLE_LAYOUT, .RATE_COMP_OFF_REQUEST, .TX_DATA, .TX_VALID,
    .TX_READY, .RX_DATA, .RX_VALID, .RATE_COMP_ENABLE, .link(link_if));
  oshp_link_asserts oshp_link_asserts_inst (.MCLK, .RST, .tx_clk(link_if.tx_clk), .tx_bus(link_if.tx_bus),
    .rx_clk(link_if.rx_clk), .rx_bus(link_if.rx_bus));

  // 250 MHz reference clock
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // Modes are static, so every change goes through a full reset of both ends
  task automatic cfg(input logic [10:0] c);
    @(posedge MCLK);
    RST <= 1'b1;
    MAC_RST <= 1'b1;
    TX_VALID <= 1'b0;
    LINE_RX_VALID <= 8'h00;
    {NIBBLE_LAYOUT, VIOLATION_FLAG_MODE, TX_CLOCKING_BIT, TX_CLOCK_SELECT_PIN, OVR_SELECT_SECOND, OVR_SELECT_HIGH,
     IFACE_SELECT_OVERRIDE, IFACE_SELECT_SECOND, IFACE_SELECT_HIGH, CODING_ENABLE_BIT, CODE_PIN} <= c;
    repeat (12) @(posedge MCLK);
    MAC_RST <= 1'b0;
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    repeat (8) @(posedge MCLK);
  endtask : cfg

  // Four pulses let steady stimulus flush the pipeline; bounded so a hang ends the run
  task automatic wait_n(input bit rx);
    int n;
    n = 0;
    for (int k = 0; k < 200 && n < 4; k++) begin
      @(posedge MCLK);
      #1;
      if ((rx ? RX_VALID : LINE_TX_VALID[0]) === 1'b1) n++;
    end
    if (n < 4) begin
      num_errors++;
      $display("unexpected at %0t: valid pulses missing", $time);
      end_of_test();
    end
  endtask : wait_n

  task automatic rx_pulse(input logic [9:0] sym);
    @(posedge MCLK);
    LINE_RX <= {8{sym}};
    LINE_RX_VALID <= 8'hff;
    @(posedge MCLK);
    LINE_RX_VALID <= 8'h00;
  endtask : rx_pulse

  // Pair A/B bus just after its transmit clock rises
  task automatic rise_beat(input logic [9:0] exp);
    logic prev;
    prev = 1'b1;
    for (int k = 0; k < 20; k++) begin
      @(posedge MCLK);
      #1;
      if (link_if.tx_clk[0] === 1'b1 && prev === 1'b0) begin
        chk(link_if.tx_bus[0], exp);
        // Ready marks the last phase, two edges after the clock rises
        chk(10'(TX_READY), 10'h000);
        repeat (2) @(posedge MCLK);
        #1;
        chk(10'(TX_READY), 10'h001);
        return;
      end
      prev = link_if.tx_clk[0];
    end
    num_errors++;
    $display("unexpected at %0t: transmit clock edge missing", $time);
    end_of_test();
  endtask : rise_beat

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Raw round trip; nibble case also runs independent clocking
  task automatic t_trip(input bit nib);
    cfg(nib ? 11'h504 : 11'h000);
    chk(10'(NIBBLE_MODE), 10'(nib));
    chk(10'(RATE_COMP_ENABLE), 10'(!nib));
    chk(10'(INDEPENDENT_CLOCKING), 10'(nib));
    @(posedge MCLK);
    for (int c = 0; c < 8; c++) TX_DATA[c] <= 10'(c * 73 + 291);
    TX_VALID <= 1'b1;
    wait_n(1'b0);
    rise_beat(nib ? {TX_DATA[1][4:0], TX_DATA[0][4:0]} : TX_DATA[1]);
    for (int c = 0; c < 8; c++) chk(LINE_TX[c], TX_DATA[c]);
    @(posedge MCLK);
    for (int c = 0; c < 8; c++) LINE_RX[c] <= 10'(c * 85 + 705);
    LINE_RX_VALID <= 8'hff;
    @(posedge MCLK);
    LINE_RX_VALID <= 8'h00;
    wait_n(1'b1);
    for (int c = 0; c < 8; c++) chk(RX_DATA[c], LINE_RX[c]);
    $display("t_trip done");
  endtask : t_trip

  // Pin and management bit sources, override and reserved layouts
  task automatic t_modes();
    logic [10:0] cf [4] = '{11'h014, 11'h030, 11'h008, 11'h050};
    for (int i = 0; i < 4; i++) begin
      cfg({2'b00, i[1], i[0], 5'h00, i[1], i[0]});
      chk(10'(CODED_MODE), 10'(i != 0));
      chk(10'(INDEPENDENT_CLOCKING), 10'(i != 0));
    end
    for (int k = 0; k < 4; k++) begin
      cfg(cf[k]);
      chk(10'(CONFIG_INVALID), 10'(k >= 2));
      if (k < 2) begin
        chk(10'(NIBBLE_MODE), 10'(k));
      end else begin
        rx_pulse(10'h2aa);
        repeat (12) @(posedge MCLK);
        #1;
        chk(link_if.rx_bus[0], 10'h000);
        chk(10'(LINE_TX_VALID), 10'h000);
      end
    end
    $display("t_modes done");
  endtask : t_modes

  // Coded transmit of a control character and decoded receive with both flag styles
  task automatic t_coded();
    logic [20:0] t [5] = '{{1'b0, 10'h17c, 10'h1bc}, {1'b1, 10'h283, 10'h1ff}, {1'b0, 10'h283, 10'h1bc},
                           {1'b1, 10'h000, 10'h1ff}, {1'b0, 10'h000, 10'h0ff}};
    cfg(11'h001);
    @(posedge MCLK);
    TX_DATA <= {8{10'h1bc}};
    TX_VALID <= 1'b1;
    wait_n(1'b0);
    for (int c = 0; c < 8; c++) chk(10'(LINE_TX[c] == 10'h17c || LINE_TX[c] == 10'h283), 10'h001);
    for (int k = 0; k < 5; k++) begin
      cfg({1'b0, t[k][20], 9'h002});
      rx_pulse(t[k][19:10]);
      wait_n(1'b1);
      for (int c = 0; c < 8; c++) chk(RX_DATA[c], t[k][9:0]);
    end
    $display("t_coded done");
  endtask : t_coded

  // Main sequence: every input has a value at time zero
  initial begin
    {RST, MAC_RST, RATE_COMP_OFF_REQUEST} = 3'b111;
    {CODE_PIN, CODING_ENABLE_BIT, IFACE_SELECT_HIGH, IFACE_SELECT_SECOND, IFACE_SELECT_OVERRIDE} = 5'h00;
    {OVR_SELECT_HIGH, OVR_SELECT_SECOND, TX_CLOCK_SELECT_PIN, TX_CLOCKING_BIT, VIOLATION_FLAG_MODE} = 5'h00;
    {NIBBLE_LAYOUT, TX_VALID, LINE_RX_VALID, TX_DATA, LINE_RX} = '0;
    t_trip(1'b0);
    t_trip(1'b1);
    t_modes();
    t_coded();
    end_of_test();
  end
endmodule : tb_octal_serdes_host_port_mode_control
